// >>> chassis_scan_defines.svh
// Constants for the chassis scan sequencer.
`ifndef CHASSIS_SCAN_DEFINES_SVH
`define CHASSIS_SCAN_DEFINES_SVH
`define CTRL_SLOT        4'hD
`define LIST_SLOT        4'hE
`define CTRL_BITS        8
`define ENTRY_BITS       16
`define LIST_DEPTH       256
`define PTR_BITS         8
`define BIT_REWIND_N     6
`define BIT_READ_EN      5
`define BIT_ONCE         4
`define BIT_RESET_N      3
`define BIT_LOAD_N       2
`define BIT_LINE_EN      1
`define BIT_TRIG_EN      0
`define CTRL_RESET       8'hFF
`define SLOT_MSB         10
`define SLOT_LSB         7
`define COUNT_MSB        6
`define COUNT_LSB        0
`endif

// >>> chassis_scan_pkg.sv
// Types for the chassis scan sequencer.
package chassis_scan_pkg;
  typedef struct packed {
    logic [3:0] slot;
    logic [6:0] count;
  } entry_type;
  typedef enum logic [1:0] {IDLE, RUN, ADVANCE, DONE} seq_state_type;
  typedef struct packed {
    logic [3:0]  selSlot;
    logic [15:0] shift;
    logic [4:0]  bitCnt;
    logic        prevFrame;
    logic        ctrlTog;
    logic        listTog;
    logic [7:0]  ctrlWord;
    entry_type   listWord;
  } link_state_type;
  typedef struct packed {
    logic [2:0]    ctrlSync;
    logic [2:0]    listSync;
    logic [7:0]    ctrl;
    logic [8:0]    wrPtr;
    logic [7:0]    rdPtr;
    logic [6:0]    sampleCnt;
    logic [3:0]    activeSlot;
    seq_state_type state;
    logic [1:0]    sclkSync;
    logic          sclkPrev;
    logic [1:0]    trigSync;
    logic [14:0]   lines;
    logic          active;
  } core_state_type;
endpackage

// >>> chassis_scan_sequencer.sv
// Slot-zero hardscan sequencer: serial control and list registers, list memory, scan walker.
`timescale 1ns/1ps
`default_nettype none
`include "chassis_scan_defines.svh"
// Overview of operation
// - Control register takes eight bits, slot thirteen.
// - Rewind bit low returns list to start.
// - Read bit gates list reads; pause advancing.
// - Once bit stops after last entry.
// - Reset bit low clears all scan state.
// - Load bit low loads counter from list.
// - Line enable off holds scan lines high.
// - List register takes sixteen bits, slot fourteen.
// - Each list write appends after prior entries.
// - List holds at most 256 entries.
// - Entry bits ten to seven give slot minus one.
// - Entry bits six to zero give count minus one.
// - Entry bits fifteen to eleven are ignored.
// - Serial data captured on serial clock rise.
module chassis_scan_sequencer
  import chassis_scan_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         serial_clock,
  input  wire logic         serial_data_in,
  input  wire logic         select_frame_n,
  input  wire logic         sample_clock,
  input  wire logic         external_trigger,
  output logic [14:0]       module_scan_line_n,
  output logic [3:0]        activeSlot,
  output logic [6:0]        sampleCount,
  output logic              scanActive
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rstSync_q;
  logic       rstCore_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstCore_n = rstSync_q[1];

  logic [1:0] linkRstSync_q;
  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      linkRstSync_q <= 2'h0;
    end else begin
      linkRstSync_q <= {linkRstSync_q[0], 1'b1};
    end
  end

  // ****************************************************************
  // Link side, on the serial clock
  // ****************************************************************
  // The serial clock only runs inside frames, so the frame edge is seen on the
  // first bit of the next frame; a completed word is committed there, or by the
  // slot-select frame (select low) that the host always sends afterwards.
  link_state_type link_q;
  link_state_type link_d;

  always_comb begin
    link_d = link_q;
    link_d.prevFrame = select_frame_n;
    if (select_frame_n && !link_q.prevFrame) begin
      link_d.bitCnt = 5'h0;
    end
    if (!select_frame_n) begin
      if (link_q.prevFrame) begin
        if (link_q.selSlot == `CTRL_SLOT && link_q.bitCnt == 5'h8) begin
          link_d.ctrlWord = link_q.shift[7:0];
          link_d.ctrlTog  = ~link_q.ctrlTog;
        end
        if (link_q.selSlot == `LIST_SLOT && link_q.bitCnt == 5'h10) begin
          link_d.listWord.slot  = link_q.shift[`SLOT_MSB:`SLOT_LSB];
          link_d.listWord.count = link_q.shift[`COUNT_MSB:`COUNT_LSB];
          link_d.listTog = ~link_q.listTog;
        end
        link_d.bitCnt = 5'h0;
      end
      link_d.shift  = {link_q.shift[14:0], serial_data_in};
      link_d.selSlot = link_d.shift[3:0];
    end else begin
      link_d.shift = {(select_frame_n && !link_q.prevFrame) ? 15'h0 : link_q.shift[14:0],
                      serial_data_in};
      if (link_d.bitCnt != 5'h1F) begin
        link_d.bitCnt = link_d.bitCnt + 5'h1;
      end
    end
  end

  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= '0;
      link_q.prevFrame <= 1'b0;
    end else if (!linkRstSync_q[1]) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // ****************************************************************
  // Core side, on mclk
  // ****************************************************************
  entry_type listMem [0:`LIST_DEPTH-1];
  entry_type headEntry;
  core_state_type core_q;
  core_state_type core_d;
  logic ctrlEvent;
  logic listEvent;
  logic sampleTick;
  logic trigOk;
  logic lastEntry;

  assign headEntry  = listMem[core_q.rdPtr];
  assign ctrlEvent  = core_q.ctrlSync[2] ^ core_q.ctrlSync[1];
  assign listEvent  = core_q.listSync[2] ^ core_q.listSync[1];
  assign sampleTick = core_q.sclkSync[1] & ~core_q.sclkPrev;
  // Trigger polarity is not pinned down; enabled means a high trigger gates sampling.
  assign trigOk     = !core_q.ctrl[`BIT_TRIG_EN] || core_q.trigSync[1];
  assign lastEntry  = ({1'b0, core_q.rdPtr} + 9'h1) >= core_q.wrPtr;

  always_ff @(posedge mclk) begin
    if (listEvent && !core_q.wrPtr[8]) begin
      listMem[core_q.wrPtr[7:0]] <= link_q.listWord;
    end
  end

  always_comb begin
    core_d = core_q;
    core_d.ctrlSync = {core_q.ctrlSync[1:0], link_q.ctrlTog};
    core_d.listSync = {core_q.listSync[1:0], link_q.listTog};
    core_d.sclkSync = {core_q.sclkSync[0], sample_clock};
    core_d.sclkPrev = core_q.sclkSync[1];
    core_d.trigSync = {core_q.trigSync[0], external_trigger};
    // Entries beyond capacity are dropped rather than overwriting the list.
    if (listEvent && !core_q.wrPtr[8]) begin
      core_d.wrPtr = core_q.wrPtr + 9'h1;
    end
    case (core_q.state)
      IDLE: begin
        if (core_q.ctrl[`BIT_READ_EN] && core_q.wrPtr != 9'h0) begin
          core_d.state = RUN;
        end
      end
      RUN: begin
        if (!core_q.ctrl[`BIT_READ_EN]) begin
          core_d.state = IDLE;
        end else if (sampleTick && trigOk) begin
          if (core_q.sampleCnt == 7'h0) begin
            core_d.state = ADVANCE;
          end else begin
            core_d.sampleCnt = core_q.sampleCnt - 7'h1;
          end
        end
      end
      ADVANCE: begin
        // Reading is paused for this one cycle while the next entry is fetched.
        if (lastEntry && core_q.ctrl[`BIT_ONCE]) begin
          core_d.state = DONE;
        end else begin
          core_d.rdPtr      = lastEntry ? 8'h0 : core_q.rdPtr + 8'h1;
          core_d.state      = RUN;
        end
      end
      DONE: begin
      end
      default: begin
        core_d.state = IDLE;
      end
    endcase
    if (core_q.state == ADVANCE && core_d.state == RUN) begin
      core_d.activeSlot = listMem[core_d.rdPtr].slot;
      core_d.sampleCnt  = listMem[core_d.rdPtr].count;
    end
    if (ctrlEvent) begin
      core_d.ctrl = link_q.ctrlWord;
      if (!link_q.ctrlWord[`BIT_REWIND_N]) begin
        core_d.rdPtr = 8'h0;
        core_d.state = IDLE;
      end
      if (!link_q.ctrlWord[`BIT_LOAD_N]) begin
        core_d.sampleCnt  = headEntry.count;
        core_d.activeSlot = headEntry.slot;
      end
      if (!link_q.ctrlWord[`BIT_RESET_N]) begin
        core_d.wrPtr      = 9'h0;
        core_d.rdPtr      = 8'h0;
        core_d.sampleCnt  = 7'h0;
        core_d.activeSlot = 4'h0;
        core_d.state      = IDLE;
      end
    end
    // Lines follow the next state, so they always agree with the slot shown beside them.
    for (int i = 0; i < 15; i++) begin
      core_d.lines[i] = !(core_d.ctrl[`BIT_LINE_EN] && core_d.state == RUN &&
                          core_d.activeSlot == i[3:0]);
    end
    core_d.active = (core_d.state == RUN) || (core_d.state == ADVANCE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_q       <= '0;
      core_q.ctrl  <= `CTRL_RESET;
      core_q.lines <= 15'h7FFF;
      core_q.state <= IDLE;
    end else if (!rstCore_n) begin
      core_q       <= '0;
      core_q.ctrl  <= `CTRL_RESET;
      core_q.lines <= 15'h7FFF;
      core_q.state <= IDLE;
    end else begin
      core_q <= core_d;
    end
  end

  // Line i drives slot i+1, since the slot number is the field plus one.
  assign module_scan_line_n = core_q.lines;
  assign activeSlot         = core_q.activeSlot;
  assign sampleCount        = core_q.sampleCnt;
  assign scanActive         = core_q.active;

endmodule
`default_nettype wire

// >>> chassis_scan_sequencer_assertions.sv
// Checker for the chassis scan sequencer outputs.
`timescale 1ns/1ps
`default_nettype none
module chassis_scan_sequencer_assertions (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        sample_clock,
  input wire logic [14:0] module_scan_line_n,
  input wire logic [3:0]  activeSlot,
  input wire logic [6:0]  sampleCount,
  input wire logic        scanActive
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire idle = (module_scan_line_n == 15'h7FFF);
  a_reset_clear: assert property (
    $rose(rst_n) |-> (idle && !scanActive && sampleCount == 7'h00 && activeSlot == 4'h0)[*2])
    else $error("outputs not cleared after reset");
  a_idle_high: assert property (!scanActive |-> idle)
    else $error("scan line low while idle");
  a_line_slot: assert property (!idle |-> module_scan_line_n == ~(15'h0001 << activeSlot))
    else $error("scan line does not match slot");
  a_one_line: assert property ($countones(~module_scan_line_n) <= 1)
    else $error("several scan lines low");
  a_count_down: assert property (
    scanActive && $past(scanActive) && $stable(activeSlot) && $past(sampleCount) != 7'h00
    |-> sampleCount == $past(sampleCount) || sampleCount == $past(sampleCount) - 7'h01)
    else $error("count moved other than one down");
  a_no_sample: assert property (
    (!sample_clock)[*6] ##1 (scanActive && $past(scanActive) && $past(sampleCount) != 7'h00)
    |-> $stable(sampleCount) && $stable(activeSlot))
    else $error("count moved without a sample");
  a_adv_zero: assert property (
    scanActive && $past(scanActive) && $changed(activeSlot) |-> $past(sampleCount) == 7'h00)
    else $error("entry advanced before count ran out");
  a_stop_hold: assert property ($fell(scanActive) |-> (!scanActive)[*8])
    else $error("scan restarted by itself");
endmodule
bind chassis_scan_sequencer chassis_scan_sequencer_assertions chassis_scan_sequencer_assertions_inst (
  .mclk, .rst_n, .sample_clock, .module_scan_line_n, .activeSlot, .sampleCount, .scanActive);
`default_nettype wire

// >>> host_link_model.sv
// Host board model writing registers over the serial link.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  output var logic serial_clock,
  output var logic serial_data_in,
  output var logic select_frame_n
);
  // ********
  // Serial writes
  // ********
  initial begin
    serial_clock = 1'b1;
    serial_data_in = 1'b0;
    select_frame_n = 1'b0;
  end
  // The clock stands high between frames and data is inverted so nothing stale looks valid.
  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = v[i];
      #16 serial_clock = 1'b0;
      #32 serial_clock = 1'b1;
      #16;
    end
    serial_data_in = ~serial_data_in;
  endtask
  task automatic put(input logic [3:0] slot, input logic [15:0] v, input int n);
    select_frame_n = 1'b0;
    send({12'h000, slot}, 16);
    select_frame_n = 1'b1;
    send(v, n);
    select_frame_n = 1'b0;
    send(16'h0000, 16);
  endtask
endmodule
`default_nettype wire

// >>> tb_chassis_scan_sequencer.sv
// Self-checking testbench for the chassis scan sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "chassis_scan_defines.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s exp %h seen %h", n, e, s); end end
module tb_chassis_scan_sequencer;
  import chassis_scan_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, sample_clock = 1'b0, external_trigger = 1'b0;
  wire         serial_clock, serial_data_in, select_frame_n, scanActive;
  logic [14:0] lines;
  logic [3:0]  slot;
  logic [6:0]  cnt;
  logic [31:0] seed = 32'hA91A;
  logic [53:0] notes[$];
  int          failures = 0, num_checks = 0;
  event        probe;
  // ********
  // Harness
  // ********
  always #5 mclk = ~mclk;
  host_link_model host_link_model_inst (.serial_clock, .serial_data_in, .select_frame_n);
  chassis_scan_sequencer chassis_scan_sequencer_inst (.mclk, .rst_n, .serial_clock,
    .serial_data_in, .select_frame_n, .sample_clock, .external_trigger,
    .module_scan_line_n(lines), .activeSlot(slot), .sampleCount(cnt), .scanActive);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [26:0] outv(input logic [3:0] s, input logic [6:0] c);
    return {~(15'h0001 << s), s, c, 1'b1};
  endfunction
  task automatic note(input logic [26:0] e, input logic [26:0] m);
    repeat (8) @(posedge mclk);
    #1;
    notes.push_back({e & m, m});
    -> probe;
  endtask
  task automatic put(input logic [3:0] s, input logic [15:0] v, input int n);
    host_link_model_inst.put(s, v, n);
  endtask
  // The trigger toggles at random; with trigger use off it must not gate counting.
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      sample_clock <= 1'b1;
      external_trigger <= ^rnd();
      repeat (4) @(posedge mclk);
      sample_clock <= 1'b0;
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(probe) begin : watch
    logic [53:0] n;
    n = notes.pop_front();
    `CHK("outputs", n[53:27], {lines, slot, cnt, scanActive} & n[26:0])
  end
  initial begin
    #300us;
    failures++;
    end_sim();
  end
  initial begin : main
    logic [15:0] ent[3];
    logic [31:0] r;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    host_link_model_inst.send(16'h0000, 2);
    note({15'h7FFF, 12'h000}, 27'h7FFFFFF);
    put(`CTRL_SLOT, 16'h00F7, `CTRL_BITS);
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      ent[i] = {r[15:11], 4'(i * 5 + 2), 5'h00, r[1:0]};
      put(`LIST_SLOT, ent[i], `ENTRY_BITS);
    end
    put(4'h5, 16'h0077, `CTRL_BITS);
    put(`CTRL_SLOT, 16'h007A, `CTRL_BITS);
    for (int i = 0; i < 3; i++) begin
      note(outv(ent[i][10:7], ent[i][6:0]), 27'h7FFFFFF);
      pulse(ent[i][6:0] + 1);
    end
    note({15'h7FFF, 12'h000}, 27'h7FFF001);
    put(`CTRL_SLOT, 16'h002E, `CTRL_BITS);
    put(`CTRL_SLOT, 16'h006A, `CTRL_BITS);
    for (int i = 0; i < 4; i++) begin
      note(outv(ent[i % 3][10:7], ent[i % 3][6:0]), 27'h7FFFFFF);
      if (i < 3) pulse(ent[i][6:0] + 1);
    end
    put(`CTRL_SLOT, 16'h006C, `CTRL_BITS);
    note({15'h7FFF, outv(ent[0][10:7], ent[0][6:0])[11:0]}, 27'h7FFFFFF);
    put(`CTRL_SLOT, 16'h00F7, `CTRL_BITS);
    note({15'h7FFF, 12'h000}, 27'h7FFFFFF);
    @(posedge mclk);
    end_sim();
  end
endmodule
`default_nettype wire
